//--- verilog/qd_pkg.sv
package qd_pkg;

	localparam int unsigned NUM_AXES = 3;
	localparam int unsigned AX_X     = 0;
	localparam int unsigned AX_Y     = 1;
	localparam int unsigned AX_Z     = 2;
	localparam int unsigned CNT_W    = 16;
	localparam int unsigned DIV_W    = 10;
	localparam int unsigned SEL_W    = 4;
	localparam int unsigned THR_W    = 7;
	localparam int unsigned GPIO_W   = 22;
	localparam int unsigned P0_W     = 8;
	localparam int unsigned P1_W     = 4;
	localparam int unsigned P2_W     = 10;

	// printed register offsets, kept as indices; byte address is four times the index
	localparam logic [31:0] IDX_CTRL     = 32'h5000_0200;
	localparam logic [31:0] IDX_XCNT     = 32'h5000_0202;
	localparam logic [31:0] IDX_YCNT     = 32'h5000_0204;
	localparam logic [31:0] IDX_CLKDIV   = 32'h5000_0206;
	localparam logic [31:0] IDX_PINSEL   = 32'h5000_0208;
	localparam logic [31:0] IDX_ZCNT     = 32'h5000_020A;
	localparam logic [31:0] IDX_EVT_STAT = 32'h5000_020C;
	localparam logic [31:0] IDX_EVT_MASK = 32'h5000_020E;

	function automatic logic [31:0] byte_addr(input logic [31:0] idx);
		return {idx[29:0], 2'b00};
	endfunction

	typedef struct packed {
		logic [5:0]       spare;
		logic [THR_W-1:0] event_threshold;
		logic             irq_pending;
		logic             irq_clear;
		logic             irq_enable;
	} qd_ctrl_t;

	typedef struct packed {
		logic [3:0]       spare;
		logic [SEL_W-1:0] z_pin_pair_select;
		logic [SEL_W-1:0] y_pin_pair_select;
		logic [SEL_W-1:0] x_pin_pair_select;
	} qd_pinsel_t;

	typedef struct packed {
		logic a;
		logic b;
	} qd_ab_t;

	localparam logic [THR_W-1:0] THR_RESET = 7'h02;
	localparam logic [THR_W-1:0] THR_MIN   = 7'h01;
	localparam logic [THR_W-1:0] THR_ZERO  = 7'h00;
	localparam logic [THR_W-1:0] EVT_MAX   = 7'h7F;
	localparam logic [SEL_W-1:0] SEL_NONE  = 4'h0;
	localparam logic [SEL_W-1:0] SEL_LAST  = 4'hA;
	localparam logic [1:0]       STEP_UP   = 2'h1;
	localparam logic [1:0]       STEP_DOWN = 2'h3;

	localparam qd_ctrl_t CTRL_RESET = '{spare: 6'h00, event_threshold: THR_RESET,
		irq_pending: 1'b0, irq_clear: 1'b0, irq_enable: 1'b0};

	// gpio vector: [7:0] port0, [11:8] port1, [21:12] port2
	function automatic qd_ab_t pick_pair(input logic [SEL_W-1:0] sel,
		input logic [GPIO_W-1:0] pins);
		qd_ab_t r;
		r = '{a: 1'b0, b: 1'b0};
		case (sel)
			4'h1: r = '{a: pins[0],  b: pins[1]};
			4'h2: r = '{a: pins[2],  b: pins[3]};
			4'h3: r = '{a: pins[4],  b: pins[5]};
			4'h4: r = '{a: pins[6],  b: pins[7]};
			4'h5: r = '{a: pins[8],  b: pins[9]};
			4'h6: r = '{a: pins[10], b: pins[11]};
			4'h7: r = '{a: pins[15], b: pins[16]};
			4'h8: r = '{a: pins[17], b: pins[18]};
			4'h9: r = '{a: pins[19], b: pins[20]};
			4'hA: r = '{a: pins[21], b: pins[12]};
			default: r = '{a: 1'b0, b: 1'b0};
		endcase
		return r;
	endfunction

	// phase position along the gray cycle 00,01,11,10
	function automatic logic [1:0] phase(input qd_ab_t s);
		return {s.a, s.a ^ s.b};
	endfunction

endpackage

//--- verilog/qd_quad_decoder.sv
`timescale 1ns/1ps
// Contract
// - a seven-bit event threshold raises the interrupt once events counted on X or Y reach it.
// - a threshold of zero acts exactly as a threshold of one.
// - the threshold resets to two.
// - a read-only pending bit at position 2 shows an interrupt that has not been cleared.
// - writing one to the clear bit at position 1 clears the pending interrupt; it reads back zero.
// - the enable bit at position 0 gates the interrupt and resets to zero.
// - X and Y each have a read-only signed 16-bit count of decoded events.
// - a disabled axis channel reads zero in its counter.
// - control at the base, X count at base plus two, Y count at base plus four.
// - a ten-bit divider holds input cycles per logic cycle minus one.
// - a four-bit selector per axis picks the pin pair; zero or above ten disables the axis.
module qd_quad_decoder
	import qd_pkg::*;
(
	input  wire  logic              clk,
	input  wire  logic              arst_n,
	input  wire  logic              psel,
	input  wire  logic              penable,
	input  wire  logic              pwrite,
	input  wire  logic [31:0]       paddr,
	input  wire  logic [31:0]       pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire  logic [P0_W-1:0]   p0_in,
	input  wire  logic [P1_W-1:0]   p1_in,
	input  wire  logic [P2_W-1:0]   p2_in,
	output logic                    irq
);

	qd_ctrl_t                  ctrl_reg;
	logic     [DIV_W-1:0]      div_reg;
	qd_pinsel_t                pinsel_reg;
	logic     [DIV_W-1:0]      tick_cnt_reg;
	logic                      tick;
	logic     [31:0]           prdata_reg;
	logic                      pslverr_reg;
	logic                      wr_en;
	logic                      setup;
	logic     [GPIO_W-1:0]     gpio;
	logic     [THR_W-1:0]      thr_eff;
	logic     [THR_W-1:0]      evt_cnt_reg [2];
	logic     [THR_W-1:0]      evt_cnt_next [2];
	logic                      thr_hit;
	logic                      clr_req;
	logic     [CNT_W-1:0]      cnt_reg [NUM_AXES];
	logic     [NUM_AXES-1:0]   ax_en;
	logic     [NUM_AXES-1:0]   ax_step;
	logic     [NUM_AXES-1:0]   ax_up;

	assign gpio    = {p2_in, p1_in, p0_in};
	assign setup   = psel && !penable;
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	// ---------------- apb slave ----------------
	// read data is caught in the setup cycle so the access phase finishes with no wait
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			case (paddr)
				byte_addr(IDX_CTRL):     prdata_reg[CNT_W-1:0] <= ctrl_reg;
				byte_addr(IDX_XCNT):     prdata_reg[CNT_W-1:0] <= cnt_reg[AX_X];
				byte_addr(IDX_YCNT):     prdata_reg[CNT_W-1:0] <= cnt_reg[AX_Y];
				byte_addr(IDX_ZCNT):     prdata_reg[CNT_W-1:0] <= cnt_reg[AX_Z];
				byte_addr(IDX_CLKDIV):   prdata_reg[DIV_W-1:0] <= div_reg;
				byte_addr(IDX_PINSEL):   prdata_reg[CNT_W-1:0] <= pinsel_reg;
				byte_addr(IDX_EVT_STAT): prdata_reg[0] <= ctrl_reg.irq_pending;
				byte_addr(IDX_EVT_MASK): prdata_reg[0] <= ctrl_reg.irq_enable;
				default:                 pslverr_reg <= 1'b1;
			endcase
		end
	end

	// ---------------- configuration ----------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg    <= '0;
			pinsel_reg <= '0;
		end else if (wr_en) begin
			if (paddr == byte_addr(IDX_CLKDIV))
				div_reg <= pwdata[DIV_W-1:0];
			if (paddr == byte_addr(IDX_PINSEL))
				pinsel_reg <= {4'h0, pwdata[3*SEL_W-1:0]};
		end
	end

	// ---------------- control register ----------------
	// irq_clear is never stored, so it always reads zero
	assign clr_req = wr_en && ((paddr == byte_addr(IDX_CTRL) && pwdata[1])
		|| (paddr == byte_addr(IDX_EVT_STAT) && pwdata[0]));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= CTRL_RESET;
		end else begin
			if (wr_en && paddr == byte_addr(IDX_CTRL)) begin
				ctrl_reg.spare           <= pwdata[15:10];
				ctrl_reg.event_threshold <= pwdata[9:3];
				ctrl_reg.irq_enable      <= pwdata[0];
			end
			if (wr_en && paddr == byte_addr(IDX_EVT_MASK))
				ctrl_reg.irq_enable <= pwdata[0];
			// a threshold hit in the clearing cycle is kept
			if (thr_hit)
				ctrl_reg.irq_pending <= 1'b1;
			else if (clr_req)
				ctrl_reg.irq_pending <= 1'b0;
			ctrl_reg.irq_clear <= 1'b0;
		end
	end

	assign irq = ctrl_reg.irq_pending && ctrl_reg.irq_enable;

	// ---------------- logic clock ----------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			tick_cnt_reg <= '0;
		else if (tick_cnt_reg >= div_reg)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 10'h001;
	end

	assign tick = (tick_cnt_reg >= div_reg);

	// ---------------- per-axis decoders ----------------
	for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
		logic       [SEL_W-1:0] sel;
		qd_ab_t                 cur;
		qd_ab_t                 prev_reg;
		logic       [1:0]       delta;

		assign sel = pinsel_reg[i*SEL_W +: SEL_W];
		assign ax_en[i] = (sel != SEL_NONE) && (sel <= SEL_LAST);
		assign cur = pick_pair(sel, gpio);
		assign delta = phase(cur) - phase(prev_reg);
		// both inputs moving at once is not a valid step and is dropped
		assign ax_step[i] = tick && ax_en[i]
			&& (delta == STEP_UP || delta == STEP_DOWN);
		assign ax_up[i] = (delta == STEP_UP);

		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n)
				prev_reg <= '{a: 1'b0, b: 1'b0};
			else if (tick)
				prev_reg <= cur;
		end

		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n)
				cnt_reg[i] <= '0;
			else if (!ax_en[i])
				cnt_reg[i] <= '0;
			else if (ax_step[i])
				cnt_reg[i] <= ax_up[i] ? cnt_reg[i] + 16'h0001
					: cnt_reg[i] - 16'h0001;
		end
	end

	// ---------------- event threshold ----------------
	assign thr_eff = (ctrl_reg.event_threshold == THR_ZERO) ? THR_MIN
		: ctrl_reg.event_threshold;

	always_comb begin
		for (int k = 0; k < 2; k++) begin
			evt_cnt_next[k] = evt_cnt_reg[k];
			if (ax_step[k] && evt_cnt_reg[k] != EVT_MAX)
				evt_cnt_next[k] = evt_cnt_reg[k] + THR_MIN;
		end
	end

	assign thr_hit = (evt_cnt_next[AX_X] >= thr_eff)
		|| (evt_cnt_next[AX_Y] >= thr_eff);

	// both tallies restart on every hit, so the next interrupt needs a fresh batch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			evt_cnt_reg[AX_X] <= '0;
			evt_cnt_reg[AX_Y] <= '0;
		end else if (thr_hit) begin
			evt_cnt_reg[AX_X] <= '0;
			evt_cnt_reg[AX_Y] <= '0;
		end else begin
			evt_cnt_reg[AX_X] <= evt_cnt_next[AX_X];
			evt_cnt_reg[AX_Y] <= evt_cnt_next[AX_Y];
		end
	end

endmodule // qd_quad_decoder

//--- bench/qd_quad_decoder_monitor.sv
`timescale 1ns/1ps
module qd_quad_decoder_monitor
	import qd_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	wire acc = psel && penable;
	wire rda = acc && !pwrite;
	wire ctl = paddr == IDX_CTRL << 2;
	wire hit = paddr inside {IDX_CTRL << 2, IDX_XCNT << 2, IDX_YCNT << 2, IDX_CLKDIV << 2,
		IDX_PINSEL << 2, IDX_ZCNT << 2, IDX_EVT_STAT << 2, IDX_EVT_MASK << 2};
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	ready_now_a: assert property (acc |-> pready) else $error("no ready");
	decode_err_a: assert property (acc |-> pslverr == !hit) else $error("bad slverr");
	hole_zero_a: assert property (rda && !hit |-> prdata == '0) else $error("hole data");
	clear_low_a: assert property (rda && ctl |-> !prdata[1]) else $error("clear bit");
	word_16_a: assert property (rda |-> prdata[31:16] == '0) else $error("upper bits");
	irq_view_a: assert property (rda && ctl |-> (prdata[2] && prdata[0]) == $past(irq))
		else $error("irq vs ctrl");
	mask_off_a: assert property (acc && pwrite && ctl && !pwdata[0] |=> !irq)
		else $error("irq not masked");
	ctrl_back_a: assert property (acc && pwrite && ctl ##1 psel && !penable && !pwrite && ctl
		|=> {prdata[15:3], prdata[0]} == {$past(pwdata[15:3], 2), $past(pwdata[0], 2)})
		else $error("ctrl readback");
	cover property (irq);
	cover property (acc && pwrite && ctl && pwdata[1]);
	cover property (acc && pslverr);
endmodule // qd_quad_decoder_monitor
bind qd_quad_decoder qd_quad_decoder_monitor u_mon (.clk(clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));

//--- bench/qd_encoder_model.sv
`timescale 1ns/1ps
// x pair on pins[1:0], y pair on pins[3:2], each as {b, a}
module qd_encoder_model (
	input  wire logic       clk,
	input  wire logic [1:0] move_x,
	input  wire logic [1:0] move_y,
	output logic      [3:0] pins
);
	logic [1:0] pos_x_reg = 2'h0;
	logic [1:0] pos_y_reg = 2'h0;
	// a move of 2 flips both lines at once, the jump a decoder must ignore
	always @(posedge clk) begin
		pos_x_reg <= pos_x_reg + move_x;
		pos_y_reg <= pos_y_reg + move_y;
	end
	assign pins = {^pos_y_reg, pos_y_reg[1], ^pos_x_reg, pos_x_reg[1]};
endmodule // qd_encoder_model

//--- bench/test_quadrature_decoder_counters.sv
`timescale 1ns/1ps
module test_quadrature_decoder_counters;
	import qd_pkg::*;
	localparam logic [31:0] CT = IDX_CTRL << 2;
	localparam logic [31:0] XC = IDX_XCNT << 2;
	localparam logic [31:0] YC = IDX_YCNT << 2;
	logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, irq;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd_q;
	logic [1:0]  mx = '0, my = '0;
	logic [3:0]  enc;
	int          errors = 0, checks_done = 0;
	qd_encoder_model ENC (.clk(clk), .move_x(mx), .move_y(my), .pins(enc));
	qd_quad_decoder DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .p0_in({4'h0, enc}), .p1_in(4'h0), .p2_in(10'h0), .irq(irq));
	initial forever #4 clk = ~clk;
	task automatic finish_test();
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// keep leaves psel up so the next setup follows at once
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic keep);
		int n = 0;
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1) begin
			errors++;
			finish_test();
		end
		rd_q = prdata;
		penable <= 1'b0;
		// one idle edge so the next call never reassigns psel in this time step
		if (!keep) begin
			psel <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
		xfer(1'b0, a, 32'h0, 1'b0);
		check(what, rd_q, exp);
	endtask
	// room for the pin change, the tick and the count update to land
	task automatic step(input logic [1:0] x, input logic [1:0] y);
		{mx, my} <= {x, y};
		@(posedge clk);
		{mx, my} <= 4'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic irq_is(input logic e);
		#1;
		check("irq", {31'h0, irq}, {31'h0, e});
		@(posedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(CT, 32'h10, "ctrl reset");
		rd(CT + 32'h4, 32'h0, "hole");
		check("slverr", {31'h0, pslverr}, 32'h1);
		xfer(1'b1, IDX_PINSEL << 2, 32'h21, 1'b0);
		xfer(1'b1, CT, 32'h19, 1'b0);
		step(2'h1, 2'h0);
		step(2'h1, 2'h3);
		irq_is(1'b0);
		step(2'h1, 2'h0);
		irq_is(1'b1);
		step(2'h2, 2'h0);
		rd(XC, 32'h3, "x count");
		rd(YC, 32'hFFFF, "y count");
		xfer(1'b1, CT, 32'h18, 1'b0);
		irq_is(1'b0);
		rd(CT, 32'h1C, "pending");
		xfer(1'b1, CT, 32'h1B, 1'b1);
		rd(CT, 32'h19, "cleared");
		xfer(1'b1, CT, 32'h1, 1'b0);
		irq_is(1'b0);
		step(2'h0, 2'h3);
		irq_is(1'b1);
		xfer(1'b1, IDX_EVT_STAT << 2, 32'h1, 1'b0);
		irq_is(1'b0);
		xfer(1'b1, IDX_PINSEL << 2, 32'hB0, 1'b0);
		rd(XC, 32'h0, "x off");
		rd(YC, 32'h0, "y off");
		rd(IDX_ZCNT << 2, 32'h0, "z off");
		rd(IDX_PINSEL << 2, 32'hB0, "pin select");
		xfer(1'b1, IDX_CLKDIV << 2, 32'h403, 1'b0);
		rd(IDX_CLKDIV << 2, 32'h3, "divider");
		finish_test();
	end
endmodule // test_quadrature_decoder_counters
